// file: shared/pwmosc_regs.vh
`ifndef PWMOSC_REGS_VH
`define PWMOSC_REGS_VH
`define PWMOSC_ADDR_W 4
`define PWMOSC_OFS_CTRL 4'h0
`define PWMOSC_OFS_UNLOCK 4'h1
`define PWMOSC_OFS_STATUS 4'h2
`define PWMOSC_CTRL_RESET 16'h0000
`define PWMOSC_BIT_OVR_SYNC 0
`define PWMOSC_BIT_SWAP 1
`define PWMOSC_BIT_OVREN_L 6
`define PWMOSC_BIT_OVREN_H 7
`define PWMOSC_BIT_OVR_LVL_L 8
`define PWMOSC_BIT_OVR_LVL_H 9
`define PWMOSC_STAT_ARMED 1
`define PWMOSC_STAT_LOCK 2
`define PWMOSC_STAT_REJECT 3
`define PWMOSC_STAT_EN 4
`define PWMOSC_CTRL_MASK 16'h03C3
`define PWMOSC_KEY1 16'hABCD
`define PWMOSC_KEY2 16'h4321
`endif

// file: rtl/pwmosc_unlock.v
`timescale 1ns/1ps
`include "pwmosc_regs.vh"
module pwmosc_unlock (
  input wire clk,
  input wire rst_n,
  input wire key_wr,
  input wire [15:0] key_data,
  input wire ctrl_wr,
  output reg armed
);
  reg stage_r;
  // two-key sequence arms one following control write
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_r <= 1'b0;
      armed <= 1'b0;
    end else if (ctrl_wr) begin
      stage_r <= 1'b0;
      armed <= 1'b0;
    end else if (key_wr) begin
      stage_r <= (key_data == `PWMOSC_KEY1);
      armed <= stage_r && (key_data == `PWMOSC_KEY2);
    end
  end
endmodule

// file: rtl/pwmosc_top.v
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "pwmosc_regs.vh"
module pwmosc_top (
  input wire MCLK,
  input wire RST_N,
  input wire [3:0] ADDR,
  input wire [15:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [15:0] RDATA,
  input wire PWM_MODULE_ENABLE,
  input wire PWM_WRITE_LOCK_CFG,
  input wire PERIOD_BOUNDARY,
  input wire GEN_HIGH,
  input wire GEN_LOW,
  output reg HIGH_SIDE_OUTPUT,
  output reg LOW_SIDE_OUTPUT
);
  // word index match on the register bus
  function reg_hit;
    input [3:0] addr;
    input [3:0] ofs;
    begin
      reg_hit = (addr == ofs);
    end
  endfunction

  // pick one of two levels by a select bit
  function pick;
    input sel;
    input when_set;
    input when_clear;
    begin
      if (sel) begin
        pick = when_set;
      end else begin
        pick = when_clear;
      end
    end
  endfunction

  // status word packing, unused bits read zero
  function [15:0] status_word;
    input enable;
    input reject;
    input lock;
    input armed_in;
    begin
      status_word = 16'h0000;
      status_word[`PWMOSC_STAT_EN] = enable;
      status_word[`PWMOSC_STAT_REJECT] = reject;
      status_word[`PWMOSC_STAT_LOCK] = lock;
      status_word[`PWMOSC_STAT_ARMED] = armed_in;
    end
  endfunction

  reg [15:0] ctrl_r;
  reg [15:0] ctrl_nxt;
  reg [1:0] ovr_act_r;
  reg [1:0] ovr_act_nxt;
  reg [1:0] ovr_en_act_r;
  reg [1:0] ovr_en_act_nxt;
  reg write_reject_r;
  reg write_reject_nxt;
  reg [15:0] rdata_nxt;
  reg high_nxt;
  reg low_nxt;
  reg src_h;
  reg src_l;
  wire armed;
  wire ctrl_sel;
  wire key_sel;
  wire ctrl_ok;
  wire [1:0] ovr_lvl;
  wire [1:0] ovr_en;
  wire swap;
  wire sync_sel;

  // bus decode and control fields
  assign ctrl_sel = WR && reg_hit(ADDR, `PWMOSC_OFS_CTRL);
  assign key_sel = WR && reg_hit(ADDR, `PWMOSC_OFS_UNLOCK);
  assign ctrl_ok = ctrl_sel && (!PWM_WRITE_LOCK_CFG || armed);
  assign ovr_lvl = {ctrl_r[`PWMOSC_BIT_OVR_LVL_H], ctrl_r[`PWMOSC_BIT_OVR_LVL_L]};
  assign ovr_en = {ctrl_r[`PWMOSC_BIT_OVREN_H], ctrl_r[`PWMOSC_BIT_OVREN_L]};
  assign swap = ctrl_r[`PWMOSC_BIT_SWAP];
  assign sync_sel = ctrl_r[`PWMOSC_BIT_OVR_SYNC];

  // unlock sequence tracker
  pwmosc_unlock u_unlock (
    .clk(MCLK),
    .rst_n(RST_N),
    .key_wr(key_sel),
    .key_data(WDATA),
    .ctrl_wr(ctrl_sel),
    .armed(armed)
  );

  // control register next value, locked writes dropped
  always @* begin
    ctrl_nxt = ctrl_r;
    if (ctrl_ok) begin
      ctrl_nxt = WDATA & `PWMOSC_CTRL_MASK;
    end
  end

  // reject flag: set by refused write, cleared by accepted one
  always @* begin
    write_reject_nxt = write_reject_r;
    if (ctrl_sel && !ctrl_ok) begin
      write_reject_nxt = 1'b1;
    end else if (ctrl_ok) begin
      write_reject_nxt = 1'b0;
    end
  end

  // control register; software keeps it fixed once enabled
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_r <= `PWMOSC_CTRL_RESET;
      write_reject_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      write_reject_r <= write_reject_nxt;
    end
  end

  // pin routing, straight or exchanged
  always @* begin
    src_h = GEN_HIGH;
    src_l = GEN_LOW;
    if (swap) begin
      src_h = GEN_LOW;
      src_l = GEN_HIGH;
    end else begin
      src_h = GEN_HIGH;
      src_l = GEN_LOW;
    end
  end

  // active override copy: immediate or at boundary
  always @* begin
    ovr_act_nxt = ovr_act_r;
    ovr_en_act_nxt = ovr_en_act_r;
    if (!sync_sel) begin
      ovr_act_nxt = ovr_lvl;
      ovr_en_act_nxt = ovr_en;
    end else if (PERIOD_BOUNDARY) begin
      ovr_act_nxt = ovr_lvl;
      ovr_en_act_nxt = ovr_en;
    end
  end

  // active override registers
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ovr_act_r <= 2'h0;
      ovr_en_act_r <= 2'h0;
    end else begin
      ovr_act_r <= ovr_act_nxt;
      ovr_en_act_r <= ovr_en_act_nxt;
    end
  end

  // pin levels, override applied after swap
  always @* begin
    high_nxt = pick(ovr_en_act_r[1], ovr_act_r[1], src_h);
    low_nxt = pick(ovr_en_act_r[0], ovr_act_r[0], src_l);
  end

  // output pins straight from flops
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      HIGH_SIDE_OUTPUT <= 1'b0;
      LOW_SIDE_OUTPUT <= 1'b0;
    end else begin
      HIGH_SIDE_OUTPUT <= high_nxt;
      LOW_SIDE_OUTPUT <= low_nxt;
    end
  end

  // read mux, zero outside a read slot
  always @* begin
    rdata_nxt = 16'h0000;
    if (RD) begin
      case (ADDR)
        `PWMOSC_OFS_CTRL: begin
          rdata_nxt = ctrl_r;
        end
        `PWMOSC_OFS_STATUS: begin
          rdata_nxt = status_word(PWM_MODULE_ENABLE, write_reject_r,
                                  PWM_WRITE_LOCK_CFG, armed);
        end
        default: begin
          rdata_nxt = 16'h0000;
        end
      endcase
    end
  end

  // read data, one cycle after strobe
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= 16'h0000;
    end else begin
      RDATA <= rdata_nxt;
    end
  end
endmodule

// file: dv/pwmosc_gate.sv
`timescale 1ns/1ps
// gate driver model, flags shoot-through
module pwmosc_gate (
  input wire logic hi,
  input wire logic lo,
  output logic both
);
  assign both = hi & lo;
endmodule

// file: dv/pwmosc_top_properties.sv
`timescale 1ns/1ps
`include "pwmosc_regs.vh"
module pwmosc_chk (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [15:0] RDATA,
  input wire logic PERIOD_BOUNDARY,
  input wire logic PWM_WRITE_LOCK_CFG,
  input wire logic GEN_HIGH,
  input wire logic GEN_LOW,
  input wire logic HIGH_SIDE_OUTPUT,
  input wire logic LOW_SIDE_OUTPUT
);
  logic [15:0] sh_r;
  logic [1:0] age_r;
  logic blind_r;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  // shadow of control writes, blind once locked
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      sh_r <= '0;
      age_r <= '0;
      blind_r <= 1'b0;
    end else begin
      if (WR && ADDR == `PWMOSC_OFS_CTRL) begin
        sh_r <= WDATA;
        blind_r <= blind_r | PWM_WRITE_LOCK_CFG;
      end
      if (age_r != 2'h3) age_r <= age_r + 2'h1;
    end
  end
  sequence calm;
    (age_r == 2'h3 && !blind_r && $stable(sh_r) && !sh_r[0])[*3];
  endsequence
  sequence sync_calm;
    (age_r == 2'h3 && !blind_r && $stable(sh_r) && sh_r[0] && sh_r[7])[*3];
  endsequence
  a_swap_high: assert property (calm ##0 !sh_r[7] |-> HIGH_SIDE_OUTPUT ==
    (sh_r[1] ? $past(GEN_LOW, 1) : $past(GEN_HIGH, 1))) else $error("high pin route");
  a_swap_low: assert property (calm ##0 !sh_r[6] |-> LOW_SIDE_OUTPUT ==
    (sh_r[1] ? $past(GEN_HIGH, 1) : $past(GEN_LOW, 1))) else $error("low pin route");
  a_ovr_high: assert property (calm ##0 sh_r[7] |-> HIGH_SIDE_OUTPUT == sh_r[9])
    else $error("high override level");
  a_ovr_low: assert property (calm ##0 sh_r[6] |-> LOW_SIDE_OUTPUT == sh_r[8])
    else $error("low override level");
  a_sync_defer: assert property (sync_calm ##0 PERIOD_BOUNDARY
    ##1 (!blind_r && $stable(sh_r))[*2] |-> HIGH_SIDE_OUTPUT == sh_r[9])
    else $error("boundary override level");
  a_read_idle: assert property (!$past(RD) |-> RDATA == 16'h0000)
    else $error("read data outside slot");
endmodule
bind pwmosc_top pwmosc_chk u_chk (.*);

// file: dv/pwm_output_swap_override_sync_test.sv
`timescale 1ns/1ps
`include "pwmosc_regs.vh"
module pwm_output_swap_override_sync_test;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, lk = 0, pb = 0, gh = 0, gl = 0, en = 0;
  logic [3:0] a = 0;
  logic [15:0] d = 0, q[$];
  wire [15:0] rdata;
  wire ho, lo, both;
  int miscompares = 0, n_compared = 0;
  pwmosc_top DUT (.MCLK(clk), .RST_N(rst_n), .ADDR(a), .WDATA(d), .WR(wr), .RD(rd),
    .RDATA(rdata), .PWM_MODULE_ENABLE(en), .PWM_WRITE_LOCK_CFG(lk), .PERIOD_BOUNDARY(pb),
    .GEN_HIGH(gh), .GEN_LOW(gl), .HIGH_SIDE_OUTPUT(ho), .LOW_SIDE_OUTPUT(lo));
  pwmosc_gate u_gate (.hi(ho), .lo(lo), .both(both));
  initial forever #2 clk = ~clk;
  task chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %0t %h %h", $time, g, e);
    end
  endtask
  task acc(input logic [3:0] ad, input logic [15:0] v, input logic w);
    @(posedge clk);
    {a, d, wr, rd} <= {ad, v, w, !w};
    @(posedge clk);
    {wr, rd} <= 2'h0;
  endtask
  task pins(input logic h, input logic l);
    repeat (4) @(posedge clk);
    #1 chk({ho, lo}, {h, l});
  endtask
  // read answer watcher, oldest note first
  always @(posedge clk) if (rd) begin
    #1 chk(rdata, q.pop_front());
  end
  task final_report;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // swap, override timing, lock; enable held low until raised for the final status read
  initial begin
    void'($urandom(67));
    repeat (10) @(posedge clk);
    rst_n <= 1;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) {gh, gl} <= 2'($urandom);
      acc(0, 16'h0002, 1);
      pins(gl, gh);
      q.push_back(16'h0002);
      acc(0, 0, 0);
      acc(0, 0, 1);
      pins(gh, gl);
    end
    $display("swap test done");
    acc(0, 16'h02C0, 1);
    pins(1, 0);
    acc(0, 16'h01C1, 1);
    pins(1, 0);
    @(posedge clk) pb <= 1;
    @(posedge clk) pb <= 0;
    pins(0, 1);
    $display("override test done");
    @(posedge clk) lk <= 1;
    acc(0, 16'h0002, 1);
    q.push_back(16'h01C1);
    acc(0, 0, 0);
    q.push_back(16'h000C);
    acc(`PWMOSC_OFS_STATUS, 0, 0);
    acc(1, `PWMOSC_KEY1, 1);
    acc(1, `PWMOSC_KEY2, 1);
    acc(0, 16'h0002, 1);
    q.push_back(16'h0002);
    acc(0, 0, 0);
    q.push_back(16'h0000);
    acc(4'hF, 0, 0);
    $display("lock test done");
    @(posedge clk) en <= 1;
    q.push_back(16'h0014);
    acc(`PWMOSC_OFS_STATUS, 0, 0);
    repeat (3) @(posedge clk);
    final_report;
  end
endmodule
